/* rtl/cmd_pkg.sv */
// Package with command codes, response types, timing constants and sizes.
// Assumes a 50 MHz single clock; used as cmd_pkg::name everywhere.
package cmd_pkg;
	localparam logic [7:0] RSP_FLAG = 8'h40;
	localparam logic [7:0] ERR_FLAG = 8'hc0;
	localparam logic [7:0] FAN_RPT_TYPE = 8'h81;
	localparam logic [5:0] CMD_REBOOT = 6'h05;
	localparam logic [5:0] CMD_CLEAR = 6'h06;
	localparam logic [5:0] CMD_LINE1 = 6'h07;
	localparam logic [5:0] CMD_LINE2 = 6'h08;
	localparam logic [5:0] CMD_GLYPH = 6'h09;
	localparam logic [5:0] CMD_READMEM = 6'h0a;
	localparam logic [5:0] CMD_CURSOR = 6'h0b;
	localparam logic [5:0] CMD_CSTYLE = 6'h0c;
	localparam logic [5:0] CMD_CONTRAST = 6'h0d;
	localparam logic [5:0] CMD_BACKLIGHT = 6'h0e;
	localparam logic [5:0] CMD_FANRPT = 6'h10;
	localparam logic [5:0] CMD_FANPWR = 6'h11;
	localparam logic [5:0] CMD_SENSOR = 6'h12;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [7:0] GLYPH_ROW_MAX = 8'h3f;
	localparam logic [7:0] FAN_PWR_MAX = 8'h64;
	localparam logic [7:0] FAN_PWR_RESET = 8'h64;
	localparam logic [7:0] COL_MAX = 8'h0f;
	localparam logic [7:0] ROW_MAX = 8'h01;
	localparam logic [7:0] SENSOR_MAX = 8'h1f;
	localparam logic [7:0] STYLE_MAX = 8'h03;
	localparam logic [7:0] ADDR_LINE1 = 8'h80;
	localparam logic [7:0] ADDR_LINE2 = 8'hc0;
	localparam logic [7:0] ADDR_GLYPH = 8'h40;
	localparam int CLK_HZ = 50000000;
	localparam int QUIET_MS = 3000;
	localparam int QUIET_CYC = CLK_HZ / 1000 * QUIET_MS;
	localparam int SLOT_MS = 125;
	localparam int SLOT_CYC = CLK_HZ / 1000 * SLOT_MS;
	localparam int CYCLE_MS = 2000;
	localparam int CYCLE_CYC = CLK_HZ / 1000 * CYCLE_MS;
endpackage

/* rtl/skid_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module skid_buffer #(
	parameter int WIDTH = 9
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Filling side.
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side.
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic [1:0] cnt;
	} buf_t;
	buf_t buf_ff;
	buf_t nxt_buf;
	logic push;
	logic pop;

	// Entry 0 is the head; a push with a pop writes at the shifted slot.
	always_comb begin
		nxt_buf = buf_ff;
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		if (pop) begin
			nxt_buf.mem[0] = buf_ff.mem[1];
		end
		if (push) begin
			if (buf_ff.cnt == 2'd0 || (pop && buf_ff.cnt == 2'd1)) begin
				nxt_buf.mem[0] = in_data_i;
			end else begin
				nxt_buf.mem[1] = in_data_i;
			end
		end
		nxt_buf.cnt = buf_ff.cnt + {1'b0, push} - {1'b0, pop};
		if (reset_i) begin
			nxt_buf = '0;
		end
	end

	// State register.
	always_ff @(posedge sys_clk_i) begin
		buf_ff <= nxt_buf;
	end

	assign in_ready_o = buf_ff.cnt != 2'd2;
	assign out_valid_o = buf_ff.cnt != 2'd0;
	assign out_data_o = buf_ff.mem[0];
endmodule

/* rtl/cmd_handler.sv */
// Command interpreter for display, glyph, cursor, fan and sensor commands.
// Assumes a byte stream of decoded packets in, a byte stream of answers out,
// and sensor identities loaded by the power-up enumeration logic.
`timescale 1ns/1ps
// Contract
// [RQ1] Answer type keeps the command's low six bits; normal answers or in 0x40.
// [RQ2] Power-off: send acknowledgement first, then cycle host, then reboot self; code strobes both in one cycle.
// [RQ3] After own reboot, commands may be ignored for up to 3 seconds.
// [RQ4] Every reboot/reset/power-off variant answers 0x45 with no payload.
// [RQ5] Clear fills text memory with spaces, cursor home, answers 0x46.
// [RQ6] Top line write takes exactly 16 bytes into the top row, answers 0x47.
// [RQ7] Bottom line write takes exactly 16 bytes into the bottom row; 0x48.
// [RQ8] Glyph command: index 0-7 then eight rows into glyph memory; 0x49.
// [RQ9] Glyph rows are 0 to 63, msb leftmost, first byte top row.
// [RQ10] Memory readback answers 0x4a, length 9: address code then eight bytes.
// [RQ11] Cursor placement: column 0-15 then row 0-1; answers 0x4b.
// [RQ12] Cursor style selects one of four looks; answers 0x4c.
// [RQ13] Contrast answers 0x4d; backlight for display and keys answers 0x4e.
// [RQ14] Nonzero fan mask: report 0x81 per enabled fan each 500 ms; ack 0x50.
// [RQ15] Successive fan reports are spaced one eighth second apart.
// [RQ16] A reported fan runs at full power for an eighth of each half second.
// [RQ17] Fan power: four bytes 0-100, one per fan; answers 0x51.
// [RQ18] Display, glyphs, cursor, contrast, backlight, fan power are saveable.
// [RQ19] Sensor identities found at power-up are kept for later queries.
// [RQ20] Sensor query index 0-31; answers 0x52 with index and 8-byte identity.
// [RQ21] Only the two thermometer family codes may be converted and reported.
// [RQ22] Host must leave pin 4 in drive mode 111, not a user pin.
// [RQ23] Bad length or field values get an error answer, state unchanged.
module cmd_handler #(
	parameter int QUIET_CYCLES = cmd_pkg::QUIET_CYC,
	parameter int SLOT_CYCLES = cmd_pkg::SLOT_CYC,
	parameter logic [7:0] THERMO_FAMILY_A = 8'h11, // Arbitrary value.
	parameter logic [7:0] THERMO_FAMILY_B = 8'h12 // Arbitrary value.
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Command packet bytes: first carries the type; last marks the end.
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_first_i,
	input wire logic cmd_last_i,
	input wire logic [7:0] cmd_data_i,
	// Answer bytes: type, length, payload; last marks the packet end.
	output logic rsp_valid_o,
	input wire logic rsp_ready_i,
	output logic [8:0] rsp_data_o,
	// Power-up sensor records, written by the enumeration logic.
	input wire logic sensor_wr_i,
	input wire logic [4:0] sensor_idx_i,
	input wire logic [63:0] sensor_id_i,
	// Fan tachometer tick counts sampled by the fan logic.
	input wire logic [3:0][15:0] fan_tach_i,
	// Display and fan settings to the hardware.
	output logic [7:0] text_mem_o [0:31],
	output logic [7:0] glyph_mem_o [0:63],
	output logic [4:0] cursor_pos_o,
	output logic [1:0] cursor_style_o,
	output logic [7:0] contrast_o,
	output logic [7:0] backlight_o,
	output logic [7:0] keypad_light_o,
	output logic [3:0][7:0] fan_power_o,
	output logic [31:0] thermo_ok_o,
	// Host power-off/reset and self reboot strobes.
	output logic host_cycle_o,
	output logic host_reset_o,
	output logic self_reboot_o
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RECV = 3'h1,
		ST_EXEC = 3'h2,
		ST_SEND = 3'h3,
		ST_QUIET = 3'h4
	} state_t;

	typedef struct packed {
		state_t st;
		logic [7:0] ctype;
		logic [4:0] cnt;
		logic [17:0][7:0] pay;
		logic [7:0] rtype;
		logic [3:0] rlen;
		logic [4:0] sidx;
		logic [8:0][7:0] rpay;
		logic [31:0] quiet;
		logic [3:0] fan_mask;
		logic [31:0] slot_tmr;
		logic [3:0] slot;
		logic rpt_due;
		logic [1:0] rpt_fan;
		logic [1:0] host_act;
		logic [31:0] thermo;
	} core_t;

	core_t st_ff;
	core_t nxt_st;
	logic [7:0] text_ff [0:31];
	logic [7:0] glyph_ff [0:63];
	logic [63:0] ident_ff [0:31];
	logic [4:0] cur_ff;
	logic [1:0] style_ff;
	logic [7:0] contrast_ff;
	logic [7:0] light_ff;
	logic [7:0] keylight_ff;
	logic [3:0][7:0] power_ff;
	logic ok;
	logic exec;
	logic [5:0] c6;
	logic [7:0] rd_addr;
	logic [1:0] fan_sel;
	logic in_valid;
	logic in_ready;
	logic [8:0] in_data;

	assign c6 = st_ff.ctype[5:0];
	assign exec = st_ff.st == ST_EXEC;

	// Field and length checks per command.
	// [RQ23] Range checks
	always_comb begin
		ok = 1'b0;
		case (c6)
			cmd_pkg::CMD_REBOOT: ok = st_ff.cnt == 5'd3;
			cmd_pkg::CMD_CLEAR: ok = st_ff.cnt == 5'd0;
			cmd_pkg::CMD_LINE1, cmd_pkg::CMD_LINE2: ok = st_ff.cnt == 5'd16;
			cmd_pkg::CMD_GLYPH: begin
				ok = st_ff.cnt == 5'd9 && st_ff.pay[0] < 8'h08;
				for (int i = 1; i < 9; i++) begin
					if (st_ff.pay[i] > cmd_pkg::GLYPH_ROW_MAX) begin
						ok = 1'b0;
					end
				end
			end
			cmd_pkg::CMD_READMEM: ok = st_ff.cnt == 5'd1;
			cmd_pkg::CMD_CURSOR: ok = st_ff.cnt == 5'd2 &&
				st_ff.pay[0] <= cmd_pkg::COL_MAX &&
				st_ff.pay[1] <= cmd_pkg::ROW_MAX;
			cmd_pkg::CMD_CSTYLE: ok = st_ff.cnt == 5'd1 &&
				st_ff.pay[0] <= cmd_pkg::STYLE_MAX;
			cmd_pkg::CMD_CONTRAST: ok = st_ff.cnt == 5'd1;
			cmd_pkg::CMD_BACKLIGHT: ok = st_ff.cnt == 5'd1 ||
				st_ff.cnt == 5'd2;
			cmd_pkg::CMD_FANRPT: ok = st_ff.cnt == 5'd1;
			cmd_pkg::CMD_FANPWR: begin
				ok = st_ff.cnt == 5'd4;
				for (int i = 0; i < 4; i++) begin
					if (st_ff.pay[i] > cmd_pkg::FAN_PWR_MAX) begin
						ok = 1'b0;
					end
				end
			end
			cmd_pkg::CMD_SENSOR: ok = st_ff.cnt == 5'd1 &&
				st_ff.pay[0] <= cmd_pkg::SENSOR_MAX;
			default: ok = 1'b0;
		endcase
	end

	// Readback address: 0x80-0x8f top row, 0xc0-0xcf bottom, 0x40 glyphs.
	assign rd_addr = st_ff.pay[0];
	// The fan is latched with the request, so a late report keeps its index.
	assign fan_sel = st_ff.rpt_fan;

	// Core sequencing: receive, execute, send, reports and quiet time.
	always_comb begin
		nxt_st = st_ff;
		in_valid = 1'b0;
		in_data = '0;
		case (st_ff.st)
			ST_IDLE: begin
				if (cmd_valid_i && cmd_first_i) begin
					nxt_st.ctype = cmd_data_i;
					nxt_st.cnt = '0;
					nxt_st.st = cmd_last_i ? ST_EXEC : ST_RECV;
				end else if (st_ff.rpt_due) begin
					// [RQ14] Fan report
					nxt_st.rpt_due = 1'b0;
					nxt_st.rtype = cmd_pkg::FAN_RPT_TYPE;
					nxt_st.rlen = 4'd3;
					nxt_st.rpay[0] = {6'h00, fan_sel};
					nxt_st.rpay[1] = fan_tach_i[fan_sel][7:0];
					nxt_st.rpay[2] = fan_tach_i[fan_sel][15:8];
					nxt_st.sidx = '0;
					nxt_st.st = ST_SEND;
				end
			end
			ST_RECV: begin
				if (cmd_valid_i) begin
					if (st_ff.cnt < 5'd18) begin
						nxt_st.pay[st_ff.cnt] = cmd_data_i;
					end
					if (st_ff.cnt != 5'd31) begin
						nxt_st.cnt = st_ff.cnt + 5'd1;
					end
					if (cmd_last_i) begin
						nxt_st.st = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				// [RQ1] Answer type
				nxt_st.rtype = {ok ? 2'b01 : 2'b11, c6};
				nxt_st.rlen = 4'd0;
				nxt_st.sidx = '0;
				nxt_st.st = ST_SEND;
				if (ok && c6 == cmd_pkg::CMD_READMEM) begin
					// [RQ10] Readback answer
					nxt_st.rlen = 4'd9;
					nxt_st.rpay[0] = rd_addr;
					for (int i = 0; i < 8; i++) begin
						if (rd_addr[7:6] == 2'b01) begin
							nxt_st.rpay[i+1] = glyph_ff[6'(rd_addr[5:0] + i)];
						end else begin
							nxt_st.rpay[i+1] =
								text_ff[{rd_addr[6], 4'(rd_addr[3:0] + i)}];
						end
					end
				end
				if (ok && c6 == cmd_pkg::CMD_SENSOR) begin
					// [RQ20] Sensor answer
					nxt_st.rlen = 4'd9;
					nxt_st.rpay[0] = st_ff.pay[0];
					for (int i = 0; i < 8; i++) begin
						nxt_st.rpay[i+1] = ident_ff[st_ff.pay[0][4:0]][8*i +: 8];
					end
				end
				if (ok && c6 == cmd_pkg::CMD_FANRPT) begin
					nxt_st.fan_mask = st_ff.pay[0][3:0];
				end
				if (ok && c6 == cmd_pkg::CMD_REBOOT) begin
					// [RQ2] Act after ack
					nxt_st.host_act = st_ff.pay[0] == 8'h08 ? 2'd1 :
						st_ff.pay[0] == 8'h0c ? 2'd2 : 2'd3;
				end
			end
			ST_SEND: begin
				in_valid = 1'b1;
				in_data = st_ff.sidx == 5'd0 ? {1'b0, st_ff.rtype} :
					st_ff.sidx == 5'd1 ? {1'b0, 4'h0, st_ff.rlen} :
					{1'b0, st_ff.rpay[st_ff.sidx - 5'd2]};
				in_data[8] = st_ff.sidx == 5'({1'b0, st_ff.rlen} + 5'd1);
				if (in_ready) begin
					nxt_st.sidx = st_ff.sidx + 5'd1;
					if (in_data[8]) begin
						nxt_st.st = st_ff.host_act != 2'd0 ? ST_QUIET : ST_IDLE;
						nxt_st.quiet = '0;
					end
				end
			end
			ST_QUIET: begin
				// [RQ3] Reboot quiet
				nxt_st.host_act = 2'd0;
				nxt_st.fan_mask = '0;
				nxt_st.quiet = st_ff.quiet + 32'd1;
				if (st_ff.quiet >= 32'(QUIET_CYCLES - 1)) begin
					nxt_st.st = ST_IDLE;
				end
			end
			default: nxt_st.st = ST_IDLE;
		endcase
		// [RQ15] Eighth second slots
		nxt_st.slot_tmr = st_ff.slot_tmr + 32'd1;
		if (st_ff.slot_tmr >= 32'(SLOT_CYCLES - 1)) begin
			nxt_st.slot_tmr = '0;
			nxt_st.slot = st_ff.slot + 4'd1;
			// Report at the start of the fan's own slot, while it runs full.
			if (st_ff.fan_mask[nxt_st.slot[1:0]]) begin
				nxt_st.rpt_due = 1'b1;
				nxt_st.rpt_fan = nxt_st.slot[1:0];
			end
		end
		if (sensor_wr_i) begin
			// [RQ21] Thermometer families
			nxt_st.thermo[sensor_idx_i] =
				sensor_id_i[7:0] == THERMO_FAMILY_A ||
				sensor_id_i[7:0] == THERMO_FAMILY_B;
		end
		if (reset_i) begin
			nxt_st = '0;
		end
	end

	// Settings and memories; updated only on a valid command.
	// [RQ18] Saved settings
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 32; i++) begin
				text_ff[i] <= cmd_pkg::SPACE_CODE;
			end
			for (int i = 0; i < 64; i++) begin
				glyph_ff[i] <= 8'h00;
			end
			cur_ff <= 5'h00;
			style_ff <= 2'h0;
			contrast_ff <= 8'h00;
			light_ff <= 8'h00;
			keylight_ff <= 8'h00;
			power_ff <= {4{cmd_pkg::FAN_PWR_RESET}};
		end else if (exec && ok) begin
			case (c6)
				cmd_pkg::CMD_CLEAR: begin
					// [RQ5] Clear screen
					for (int i = 0; i < 32; i++) begin
						text_ff[i] <= cmd_pkg::SPACE_CODE;
					end
					cur_ff <= 5'h00;
				end
				cmd_pkg::CMD_LINE1, cmd_pkg::CMD_LINE2: begin
					// [RQ6] [RQ7] Line writes
					for (int i = 0; i < 16; i++) begin
						text_ff[{c6 == cmd_pkg::CMD_LINE2, 4'(i)}] <= st_ff.pay[i];
					end
				end
				cmd_pkg::CMD_GLYPH: begin
					// [RQ8] [RQ9] Glyph rows
					for (int i = 0; i < 8; i++) begin
						glyph_ff[{st_ff.pay[0][2:0], 3'(i)}] <= st_ff.pay[i+1];
					end
				end
				cmd_pkg::CMD_CURSOR: begin
					// [RQ11] Cursor place
					cur_ff <= {st_ff.pay[1][0], st_ff.pay[0][3:0]};
				end
				// [RQ12] Cursor style
				cmd_pkg::CMD_CSTYLE: style_ff <= st_ff.pay[0][1:0];
				// [RQ13] Contrast and light
				cmd_pkg::CMD_CONTRAST: contrast_ff <= st_ff.pay[0];
				cmd_pkg::CMD_BACKLIGHT: begin
					light_ff <= st_ff.pay[0];
					keylight_ff <= st_ff.cnt == 5'd2 ? st_ff.pay[1] : st_ff.pay[0];
				end
				cmd_pkg::CMD_FANPWR: begin
					// [RQ17] Fan power
					for (int i = 0; i < 4; i++) begin
						power_ff[i] <= st_ff.pay[i];
					end
				end
				default: ;
			endcase
		end
	end

	// Sensor identity store, filled at power-up enumeration.
	// [RQ19] Keep identities
	always_ff @(posedge sys_clk_i) begin
		if (sensor_wr_i) begin
			ident_ff[sensor_idx_i] <= sensor_id_i;
		end
	end

	// Core state register.
	always_ff @(posedge sys_clk_i) begin
		st_ff <= nxt_st;
	end

	skid_buffer #(.WIDTH(9)) u_rsp_buf (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.in_valid_i(in_valid),
		.in_ready_o(in_ready),
		.in_data_i(in_data),
		.out_valid_o(rsp_valid_o),
		.out_ready_i(rsp_ready_i),
		.out_data_o(rsp_data_o)
	);

	assign cmd_ready_o = st_ff.st == ST_IDLE || st_ff.st == ST_RECV;
	assign text_mem_o = text_ff;
	assign glyph_mem_o = glyph_ff;
	assign cursor_pos_o = cur_ff;
	assign cursor_style_o = style_ff;
	assign contrast_o = contrast_ff;
	assign backlight_o = light_ff;
	assign keypad_light_o = keylight_ff;
	assign thermo_ok_o = st_ff.thermo;

	// A reported fan is forced full in its own eighth of each half second.
	// [RQ16] Full power override
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			fan_power_o[i] = (st_ff.fan_mask[i] && st_ff.slot[1:0] == 2'(i))
				? cmd_pkg::FAN_PWR_MAX : power_ff[i];
		end
	end

	// Host actions fire on entry to quiet time, after the ack is queued.
	assign self_reboot_o = st_ff.st == ST_QUIET && st_ff.quiet == 32'd0;
	assign host_cycle_o = self_reboot_o && st_ff.host_act == 2'd3;
	assign host_reset_o = self_reboot_o && st_ff.host_act == 2'd2;
endmodule

/* dv/cmd_handler_asserts.sv */
// Port checks for the command handler, bound into every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cmd_handler_asserts (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Command and answer streams.
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire logic cmd_first_i,
	input wire logic cmd_last_i,
	input wire logic [7:0] cmd_data_i,
	input wire logic rsp_valid_o,
	input wire logic rsp_ready_i,
	input wire logic [8:0] rsp_data_o,
	// Settings and strobes.
	input wire logic [7:0] text_mem_o [0:31],
	input wire logic [4:0] cursor_pos_o,
	input wire logic [3:0][7:0] fan_power_o,
	input wire logic host_cycle_o,
	input wire logic host_reset_o,
	input wire logic self_reboot_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	logic [4:0] idx_ff;
	logic [7:0] ptype_ff;
	logic [7:0] ctype_ff;
	logic ack_ff;
	logic take;
	logic first;
	logic [7:0] ty;
	logic strobe;
	// Type of the answer under way; byte 0 shows it directly.
	assign take = rsp_valid_o && rsp_ready_i;
	assign first = cmd_valid_i && cmd_ready_o && cmd_first_i;
	assign ty = (idx_ff == 5'h00) ? rsp_data_o[7:0] : ptype_ff;
	assign strobe = host_cycle_o || host_reset_o || self_reboot_o;
	// Tracks answer position, last command type and a seen 0x45 answer.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			idx_ff <= 5'h00;
			ptype_ff <= 8'h00;
			ctype_ff <= 8'h00;
			ack_ff <= 1'b0;
		end else begin
			if (take) begin
				idx_ff <= rsp_data_o[8] ? 5'h00 : idx_ff + 5'h01;
				ptype_ff <= ty;
			end
			if (first)
				ctype_ff <= cmd_data_i;
			if (rsp_valid_o && idx_ff == 5'h00 && rsp_data_o[7:0] == 8'h45)
				ack_ff <= 1'b1;
			else if (first)
				ack_ff <= 1'b0;
		end
	end
	a_type_echo: assert property (rsp_valid_o && idx_ff == 5'h00 &&
		rsp_data_o[7:0] != 8'h81 |-> rsp_data_o[5:0] == ctype_ff[5:0])
		else $error("answer type does not echo command");
	a_answer_due: assert property (cmd_valid_i && cmd_ready_o &&
		cmd_last_i |-> ##[1:40] rsp_valid_o)
		else $error("no answer after command");
	a_ack_empty: assert property (rsp_valid_o && idx_ff == 5'h01 &&
		(ptype_ff == 8'h45 || ptype_ff[7:6] == 2'b11) |->
		rsp_data_o == 9'h100) else $error("ack or error not empty");
	a_readback_len: assert property (rsp_valid_o && idx_ff == 5'h01 &&
		(ptype_ff == 8'h4a || ptype_ff == 8'h52) |-> rsp_data_o == 9'h009)
		else $error("readback length wrong");
	a_report_len: assert property (rsp_valid_o && idx_ff == 5'h01 &&
		ptype_ff == 8'h81 |-> rsp_data_o == 9'h003)
		else $error("fan report length wrong");
	a_clear_home: assert property (rsp_valid_o && idx_ff == 5'h00 &&
		rsp_data_o[7:0] == 8'h46 |-> cursor_pos_o == 5'h00 &&
		text_mem_o[0] == 8'h20 && text_mem_o[31] == 8'h20)
		else $error("clear left text or cursor");
	a_fan_limit: assert property (fan_power_o[0] <= 8'h64 &&
		fan_power_o[1] <= 8'h64 && fan_power_o[2] <= 8'h64 &&
		fan_power_o[3] <= 8'h64) else $error("fan power above full");
	a_ack_first: assert property (strobe |-> ack_ff ||
		(rsp_valid_o && rsp_data_o[7:0] == 8'h45))
		else $error("strobe before acknowledgement");
	a_quiet_hold: assert property (strobe |=> !cmd_ready_o [*8])
		else $error("commands taken during quiet time");
	a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=>
		rsp_valid_o && $stable(rsp_data_o)) else $error("answer dropped");
	c_clear: cover property (rsp_valid_o && rsp_data_o[7:0] == 8'h46);
	c_report: cover property (take && ty == 8'h81);
	c_error: cover property (take && idx_ff == 5'h00 && ty[7:6] == 2'b11);
endmodule
bind cmd_handler cmd_handler_asserts u_chk (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
	.cmd_ready_o(cmd_ready_o), .cmd_first_i(cmd_first_i),
	.cmd_last_i(cmd_last_i), .cmd_data_i(cmd_data_i),
	.rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
	.rsp_data_o(rsp_data_o), .text_mem_o(text_mem_o),
	.cursor_pos_o(cursor_pos_o), .fan_power_o(fan_power_o),
	.host_cycle_o(host_cycle_o), .host_reset_o(host_reset_o),
	.self_reboot_o(self_reboot_o)
);

/* dv/host_model.sv */
// Host model: sends command packets and gathers answer bytes.
// Assumes answers follow the valid/ready handshake on one clock.
`timescale 1ns/1ps
module host_model (
	// Clock and stall control.
	input wire logic sys_clk_i,
	input wire logic slow_i,
	// Command side.
	output logic cmd_valid_o,
	input wire logic cmd_ready_i,
	output logic cmd_first_o,
	output logic cmd_last_o,
	output logic [7:0] cmd_data_o,
	// Answer side.
	input wire logic rsp_valid_i,
	output logic rsp_ready_o,
	input wire logic [8:0] rsp_data_i
);
	logic [7:0] pl [0:17];
	logic [8:0] rq [$];
	initial begin
		cmd_valid_o = 1'b0;
		cmd_first_o = 1'b0;
		cmd_last_o = 1'b0;
		cmd_data_o = 8'h00;
		rsp_ready_o = 1'b1;
	end
	// Gathers every byte taken; a slow host stalls every other cycle.
	always @(posedge sys_clk_i) begin
		if (rsp_valid_i && rsp_ready_o)
			rq.push_back(rsp_data_i);
		rsp_ready_o <= slow_i ? !rsp_ready_o : 1'b1;
	end
	// Holds each byte until ready, so quiet time is respected.
	task send(input logic [7:0] t, input int n);
		for (int i = -1; i < n; i++) begin
			cmd_valid_o <= 1'b1;
			cmd_first_o <= (i < 0);
			cmd_last_o <= (i == n - 1);
			cmd_data_o <= (i < 0) ? t : pl[i];
			@(posedge sys_clk_i);
			while (!cmd_ready_i)
				@(posedge sys_clk_i);
		end
		cmd_valid_o <= 1'b0;
		cmd_data_o <= ~cmd_data_o;
	endtask
	// Pops one whole answer packet, waiting for it if needed.
	task recv(output logic [8:0] q [$]);
		q = {};
		while (q.size() == 0 || !q[$][8]) begin
			while (rq.size() == 0)
				@(posedge sys_clk_i);
			q.push_back(rq.pop_front());
		end
	endtask
endmodule

/* dv/lcd_fan_sensor_cmd_handler_tb.sv */
// Self-checking bench for the command handler.
// Assumes the host model and the bound checker from this folder.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
	$display("unexpected %s: exp %h seen %h", nm, e, a); end end
module lcd_fan_sensor_cmd_handler_tb;
	localparam logic [7:0] FAM_A = 8'h5a; // Arbitrary value.
	localparam logic [7:0] FAM_B = 8'h5b; // Arbitrary value.
	localparam logic [63:0] SID = {56'h17161514131211, FAM_A};
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic slow = 1'b0;
	logic cmd_valid_i, cmd_ready_o, cmd_first_i, cmd_last_i;
	logic [7:0] cmd_data_i;
	logic rsp_valid_o, rsp_ready_i;
	logic [8:0] rsp_data_o;
	logic sensor_wr_i = 1'b0;
	logic [4:0] sensor_idx_i = 5'h00;
	logic [63:0] sensor_id_i = 64'h0;
	logic [3:0][15:0] fan_tach_i = {16'h4404, 16'h3303, 16'h2202, 16'h1101};
	logic [7:0] text_mem_o [0:31];
	logic [7:0] glyph_mem_o [0:63];
	logic [4:0] cursor_pos_o;
	logic [1:0] cursor_style_o;
	logic [7:0] contrast_o, backlight_o, keypad_light_o;
	logic [3:0][7:0] fan_power_o;
	logic [31:0] thermo_ok_o;
	logic host_cycle_o, host_reset_o, self_reboot_o;
	logic [8:0] p [$];
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int n_cyc = 0;
	int n_rst = 0;
	int n_boot = 0;
	// Clock at 50 MHz.
	always #10 sys_clk_i = ~sys_clk_i;
	// Counts cycles and the outgoing strobes.
	always @(posedge sys_clk_i) begin
		cyc++;
		n_cyc += host_cycle_o;
		n_rst += host_reset_o;
		n_boot += self_reboot_o;
	end
	host_model host (.sys_clk_i(sys_clk_i), .slow_i(slow),
		.cmd_valid_o(cmd_valid_i), .cmd_ready_i(cmd_ready_o),
		.cmd_first_o(cmd_first_i), .cmd_last_o(cmd_last_i),
		.cmd_data_o(cmd_data_i), .rsp_valid_i(rsp_valid_o),
		.rsp_ready_o(rsp_ready_i), .rsp_data_i(rsp_data_o));
	cmd_handler #(.QUIET_CYCLES(50), .SLOT_CYCLES(20),
		.THERMO_FAMILY_A(FAM_A), .THERMO_FAMILY_B(FAM_B)) dut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
		.cmd_first_i(cmd_first_i), .cmd_last_i(cmd_last_i),
		.cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
		.rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o),
		.sensor_wr_i(sensor_wr_i), .sensor_idx_i(sensor_idx_i),
		.sensor_id_i(sensor_id_i), .fan_tach_i(fan_tach_i),
		.text_mem_o(text_mem_o), .glyph_mem_o(glyph_mem_o),
		.cursor_pos_o(cursor_pos_o), .cursor_style_o(cursor_style_o),
		.contrast_o(contrast_o), .backlight_o(backlight_o),
		.keypad_light_o(keypad_light_o), .fan_power_o(fan_power_o),
		.thermo_ok_o(thermo_ok_o), .host_cycle_o(host_cycle_o),
		.host_reset_o(host_reset_o), .self_reboot_o(self_reboot_o));
	task test_done();
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One command and its answer; fan reports in between are skipped.
	task xact(input logic [7:0] t, input int n, input logic [7:0] et,
		input logic [7:0] el);
		host.send(t, n);
		do host.recv(p); while (p[0][7:0] == 8'h81);
		`CHK("type", {1'b0, et}, p[0])
		`CHK("length", {1'b1, el}, p[1] | 9'h100)
	endtask
	task t_cursor();
		host.pl[0] = 8'h0f;
		host.pl[1] = 8'h01;
		xact(8'h0b, 2, 8'h4b, 8'h00);
		`CHK("cursor", 5'h1f, cursor_pos_o)
		host.pl[0] = 8'h10;
		xact(8'h0b, 2, 8'hcb, 8'h00);
		`CHK("cursor kept", 5'h1f, cursor_pos_o)
		for (int s = 0; s < 4; s++) begin
			host.pl[0] = 8'(s);
			xact(8'h0c, 1, 8'h4c, 8'h00);
			`CHK("style", 2'(s), cursor_style_o)
		end
		host.pl[0] = 8'h37;
		xact(8'h0d, 1, 8'h4d, 8'h00);
		`CHK("contrast", 8'h37, contrast_o)
		host.pl[0] = 8'h50;
		host.pl[1] = 8'h21;
		xact(8'h0e, 2, 8'h4e, 8'h00);
		`CHK("light", 16'h5021, {backlight_o, keypad_light_o})
	endtask
	task t_lines();
		for (int i = 0; i < 16; i++)
			host.pl[i] = 8'h41 + 8'(i);
		xact(8'h07, 16, 8'h47, 8'h00);
		for (int i = 0; i < 16; i++)
			host.pl[i] = 8'h61 + 8'(i);
		xact(8'h08, 16, 8'h48, 8'h00);
		for (int i = 0; i < 16; i++) begin
			`CHK("top", 8'h41 + 8'(i), text_mem_o[i])
			`CHK("bottom", 8'h61 + 8'(i), text_mem_o[16 + i])
		end
		xact(8'h07, 15, 8'hc7, 8'h00);
		`CHK("kept", 8'h41, text_mem_o[0])
		host.pl[0] = 8'hc8;
		xact(8'h0a, 1, 8'h4a, 8'h09);
		`CHK("addr", 9'h0c8, p[2])
		for (int i = 0; i < 8; i++)
			`CHK("text rb", {i == 7, 8'h69 + 8'(i)}, p[3 + i])
		xact(8'h06, 0, 8'h46, 8'h00);
		for (int i = 0; i < 32; i++)
			`CHK("space", 8'h20, text_mem_o[i])
		`CHK("home", 5'h00, cursor_pos_o)
	endtask
	task t_glyph();
		host.pl[0] = 8'h07;
		for (int r = 0; r < 8; r++)
			host.pl[1 + r] = 8'h38 + 8'(r);
		xact(8'h09, 9, 8'h49, 8'h00);
		for (int r = 0; r < 8; r++)
			`CHK("glyph", 8'h38 + 8'(r), glyph_mem_o[56 + r])
		host.pl[0] = 8'h78;
		xact(8'h0a, 1, 8'h4a, 8'h09);
		for (int r = 0; r < 8; r++)
			`CHK("glyph rb", {r == 7, 8'h38 + 8'(r)}, p[3 + r])
		host.pl[0] = 8'h07;
		host.pl[8] = 8'h40;
		xact(8'h09, 9, 8'hc9, 8'h00);
		`CHK("glyph kept", 8'h3f, glyph_mem_o[63])
	endtask
	task t_fan();
		int t0;
		host.pl[0] = 8'h00;
		host.pl[1] = 8'h32;
		host.pl[2] = 8'h64;
		host.pl[3] = 8'h07;
		xact(8'h11, 4, 8'h51, 8'h00);
		`CHK("fans", 32'h07643200, fan_power_o)
		host.pl[2] = 8'h65;
		xact(8'h11, 4, 8'hd1, 8'h00);
		`CHK("fans kept", 32'h07643200, fan_power_o)
		slow <= 1'b1;
		host.pl[0] = 8'h02;
		xact(8'h10, 1, 8'h50, 8'h00);
		host.recv(p);
		`CHK("override", 16'h6400, fan_power_o[1:0])
		`CHK("report", {9'h001, 9'h002, 9'h122}, {p[2], p[3], p[4]})
		// The first report may trail the setup answer; time later ones.
		host.recv(p);
		t0 = cyc;
		host.recv(p);
		`CHK("period", 1'b1, (cyc - t0 >= 78 && cyc - t0 <= 82))
		host.pl[0] = 8'h00;
		xact(8'h10, 1, 8'h50, 8'h00);
		slow <= 1'b0;
	endtask
	task t_sensor();
		host.pl[0] = 8'h03;
		xact(8'h12, 1, 8'h52, 8'h09);
		`CHK("index", 9'h003, p[2])
		for (int b = 0; b < 8; b++)
			`CHK("ident", {b == 7, SID[8 * b +: 8]}, p[3 + b])
		`CHK("thermo", 2'b01, thermo_ok_o[4:3])
		host.pl[0] = 8'h20;
		xact(8'h12, 1, 8'hd2, 8'h00);
	endtask
	task t_reboot();
		logic [7:0] v [3];
		v = '{8'h08, 8'h0c, 8'h03};
		for (int k = 0; k < 3; k++) begin
			host.pl[0] = v[k];
			xact(8'h05, 3, 8'h45, 8'h00);
		end
		xact(8'h06, 0, 8'h46, 8'h00);
		`CHK("strobes", 2'b11, {n_rst == 1, n_cyc == 1})
		`CHK("reboot", 1'b1, n_boot == 3)
	endtask
	// Watchdog well beyond the expected several hundred cycles.
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		test_done();
	end
	// Reset, power-up sensor records, then the scenarios.
	initial begin
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		sensor_wr_i <= 1'b1;
		sensor_idx_i <= 5'h03;
		sensor_id_i <= SID;
		@(posedge sys_clk_i);
		sensor_idx_i <= 5'h04;
		sensor_id_i <= {56'h1, 8'h01};
		@(posedge sys_clk_i);
		sensor_wr_i <= 1'b0;
		t_cursor();
		t_lines();
		t_glyph();
		t_fan();
		t_sensor();
		t_reboot();
		test_done();
	end
endmodule
